/* File: verilog/hwmon_alert_and_power_ctrl.v */
`timescale 1ns/1ps
`include "hwmon_alert_consts.vh"
module hwmon_alert_and_power_ctrl (
   input wire clk,
   input wire resetn,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   output reg reg_rvalid,
   input wire alert_response,
   input wire conv_valid,
   input wire [2:0] conv_chan,
   input wire [7:0] conv_code,
   input wire [1:0] diode_fault,
   input wire [3:0] fan_err,
   input wire [4:0] cpu_voltage_code_pins,
   output reg alert_n,
   output reg fan_drive_2_pin,
   output reg fan_drive_2_oe,
   output reg speed_sense_3_pin,
   output reg speed_sense_3_oe,
   output reg fans_full,
   output reg monitoring,
   output reg osc_run
);
   localparam MODE_MON = 2'b00;
   localparam MODE_SLEEP = 2'b01;
   localparam MODE_SHUT = 2'b10;

   reg [7:0] ctrl_q, sfr_q, ven_q, pin_share_config_q, fen_q, ten_q;
   reg [7:0] stat1_q, stat2_q, vid_q;
   reg [7:0] rd_q [0:7];
   reg [7:0] viol_q;
   reg [1:0] mode_q;
   reg released_q;
   reg [7:0] rdata_d;
   reg [7:0] viol_d;
   wire [7:0] lim_lo;
   wire [7:0] lim_hi;
   wire [127:0] lim_flat;
   wire lim_hit;
   wire lim_we;
   wire shut;
   wire rd_stat1, rd_stat2;
   wire [7:0] src1, src2;
   wire temp_any, volt_any, fan_any, any_stat, alert_d;
   wire [7:0] code_eff;
   integer k;

   function in_range;
      input [7:0] a;
      input [7:0] base;
      input [7:0] n;
      begin
         in_range = (a >= base) && (a < base + n);
      end
   endfunction

   function [7:0] chan_addr;
      input [2:0] c;
      begin
         chan_addr = `REG_RD_VCC + {5'h00, c};
      end
   endfunction

   // One event group asks for the alert when its enable and any of its status bits are set.
   function group_alert;
      input grp_en;
      input [7:0] bits;
      begin
         group_alert = grp_en && (|bits);
      end
   endfunction

   // Even slots of the limit store hold low limits, odd slots high limits.
   function [7:0] lim_byte;
      input [127:0] f;
      input [3:0] idx;
      begin
         lim_byte = f[idx*8 +: 8];
      end
   endfunction

   // Temperatures compare as two's complement so the sensor-error code lies below any sane low limit.
   function out_of_window;
      input [7:0] code;
      input [7:0] lo;
      input [7:0] hi;
      input two_c;
      begin
         if (two_c) begin
            out_of_window = ($signed(code) < $signed(lo)) || ($signed(code) > $signed(hi));
         end else begin
            out_of_window = (code < lo) || (code > hi);
         end
      end
   endfunction

   assign shut = (mode_q == MODE_SHUT);
   assign lim_hit = in_range(reg_addr, `REG_LIM_BASE, 8'h10);
   assign lim_we = reg_wr && lim_hit && !shut;
   wire [7:0] lim_off = reg_addr - `REG_LIM_BASE;

   lim_mem u_lim (
      .clk(clk),
      .resetn(resetn),
      .we(lim_we),
      .waddr(lim_off[3:0]),
      .wdata(reg_wdata),
      .raddr(lim_off[3:0]),
      .rdata(),
      .flat(lim_flat)
   );

   assign lim_lo = lim_byte(lim_flat, {conv_chan, 1'b0});
   assign lim_hi = lim_byte(lim_flat, {conv_chan, 1'b1});

   // A faulted diode channel reads as the sensor-error code so its limit trips.
   assign code_eff = (conv_chan == 3'd5 && diode_fault[0]) ? `DIODE_FAULT_CODE :
                     (conv_chan == 3'd7 && diode_fault[1]) ? `DIODE_FAULT_CODE : conv_code;

   // Current violation per channel, signed compare for temperatures.
   always @* begin
      viol_d = viol_q;
      if (conv_valid && mode_q == MODE_MON) begin
         viol_d[conv_chan] = out_of_window(code_eff, lim_lo, lim_hi, conv_chan >= 3'd5);
      end
   end

   // Status layout: stat1 bit n is channel n (supplies 4:0, temps 7:5), stat2[3:0] fans, [7:6] faults.
   assign src1 = viol_d & {ten_q[`TEN_REM2_BIT], ten_q[`TEN_AMB_BIT], ten_q[`TEN_REM1_BIT], ven_q[5:1]};
   assign src2 = {diode_fault, 2'b00, fan_err & fen_q[4:1]};
   assign rd_stat1 = reg_rd && reg_addr == `REG_STAT1 && !shut;
   assign rd_stat2 = reg_rd && reg_addr == `REG_STAT2 && !shut;

   assign temp_any = group_alert(ten_q[`GRP_BIT], {5'b00000, stat1_q[`ST1_REM2_BIT], stat1_q[`ST1_AMB_BIT],
                     stat1_q[`ST1_REM1_BIT]});
   assign volt_any = group_alert(ven_q[`GRP_BIT], {3'b000, stat1_q[4:0]});
   assign fan_any = group_alert(fen_q[`GRP_BIT], {4'h0, stat2_q[3:0]});
   assign any_stat = temp_any | volt_any | fan_any;
   assign alert_d = sfr_q[`GEN_BIT] && any_stat && (mode_q == MODE_MON) && !released_q;

   always @* begin
      rdata_d = 8'h00;
      if (!shut) begin
         case (reg_addr)
            `REG_CTRL: rdata_d = ctrl_q;
            `REG_STAT1: rdata_d = stat1_q;
            `REG_STAT2: rdata_d = stat2_q;
            `REG_VID: rdata_d = vid_q;
            `REG_SFR: rdata_d = sfr_q;
            `REG_VEN: rdata_d = ven_q;
            `REG_PIN_SHARE_CONFIG: rdata_d = pin_share_config_q;
            `REG_FEN: rdata_d = fen_q;
            `REG_TEN: rdata_d = ten_q;
            default: begin
               if (reg_addr[7:3] == 5'b00100) begin
                  rdata_d = rd_q[reg_addr[2:0]];
               end else if (lim_hit) begin
                  rdata_d = lim_byte(lim_flat, lim_off[3:0]);
               end
            end
         endcase
      end
   end

   // Host-visible control and enable registers.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= `RST_CTRL;
         sfr_q <= `RST_SFR;
         ven_q <= `RST_EN;
         pin_share_config_q <= `RST_PIN_SHARE_CONFIG;
         fen_q <= `RST_EN;
         ten_q <= `RST_EN;
      end else begin
         if (reg_wr) begin
            case (reg_addr)
               `REG_CTRL: if (!shut) begin
                  if (!ctrl_q[`LOCK_BIT]) begin
                     ctrl_q[`START_BIT] <= reg_wdata[`START_BIT];
                  end
                  ctrl_q[`LOCK_BIT] <= ctrl_q[`LOCK_BIT] | reg_wdata[`LOCK_BIT];
               end
               `REG_SFR: begin
                  sfr_q[`GEN_BIT:1] <= reg_wdata[`GEN_BIT:1];
                  if (!ctrl_q[`LOCK_BIT]) begin
                     sfr_q[`LOWPOWER_SELECT_BIT] <= reg_wdata[`LOWPOWER_SELECT_BIT];
                  end
                  if (!shut) begin
                     sfr_q[7:3] <= reg_wdata[7:3];
                  end
               end
               `REG_PIN_SHARE_CONFIG: pin_share_config_q <= reg_wdata;
               `REG_VEN: if (!shut) ven_q <= reg_wdata;
               `REG_FEN: if (!shut) fen_q <= reg_wdata;
               `REG_TEN: if (!shut) ten_q <= reg_wdata;
               // Status, reading and identity addresses land here, so host writes to them are dropped.
               default: ;
            endcase
         end
      end
   end

   // Set wins over the read-clear: a live source keeps its bit.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stat1_q <= 8'h00;
         stat2_q <= 8'h00;
         vid_q <= 8'h00;
         viol_q <= 8'h00;
         for (k = 0; k < 8; k = k + 1) begin
            rd_q[k] <= 8'h00;
         end
      end else begin
         viol_q <= viol_d;
         vid_q <= {3'b000, cpu_voltage_code_pins};
         if (conv_valid && mode_q == MODE_MON) begin
            rd_q[conv_chan] <= code_eff;
         end
         stat1_q <= (rd_stat1 ? 8'h00 : stat1_q) | src1;
         stat2_q <= (rd_stat2 ? 8'h00 : stat2_q) | src2;
      end
   end

   // Mode follows the control bits one cycle after the write that changes them.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= MODE_SLEEP;
      end else begin
         if (ctrl_q[`START_BIT]) begin
            mode_q <= MODE_MON;
         end else if (sfr_q[`LOWPOWER_SELECT_BIT]) begin
            mode_q <= MODE_SHUT;
         end else begin
            mode_q <= MODE_SLEEP;
         end
      end
   end

   // The release lasts until the sources are gone or the host toggles the global enable.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         released_q <= 1'b0;
      end else begin
         if (alert_response && !alert_n) begin
            released_q <= 1'b1;
         end else if (!any_stat || !sfr_q[`GEN_BIT]) begin
            released_q <= 1'b0;
         end
      end
   end

   // Bus answer registers.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd && !shut;
         reg_rdata <= rdata_d;
      end
   end

   // Pins and mode flags are flip-flops so they never glitch while the sources settle.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         alert_n <= 1'b1;
         fan_drive_2_pin <= 1'b1;
         fan_drive_2_oe <= 1'b0;
         speed_sense_3_pin <= 1'b1;
         speed_sense_3_oe <= 1'b0;
         fans_full <= 1'b1;
         monitoring <= 1'b0;
         osc_run <= 1'b1;
      end else begin
         alert_n <= !alert_d;
         fan_drive_2_oe <= pin_share_config_q[`DRV2_BIT];
         fan_drive_2_pin <= !alert_d;
         speed_sense_3_oe <= pin_share_config_q[`SNS3_BIT];
         speed_sense_3_pin <= !alert_d;
         fans_full <= mode_q != MODE_MON;
         monitoring <= mode_q == MODE_MON;
         osc_run <= mode_q != MODE_SHUT;
      end
   end
endmodule

/* File: verilog/hwmon_alert_consts.vh */
`ifndef HWMON_ALERT_CONSTS_VH
`define HWMON_ALERT_CONSTS_VH
`define REG_CTRL 8'h40
`define REG_STAT1 8'h41
`define REG_STAT2 8'h42
`define REG_VID 8'h43
`define REG_RD_VCC 8'h20
`define REG_RD_12V 8'h21
`define REG_RD_5V 8'h22
`define REG_RD_25V 8'h23
`define REG_RD_CPU 8'h24
`define REG_RD_REM1 8'h25
`define REG_RD_AMB 8'h26
`define REG_RD_REM2 8'h27
`define REG_LIM_BASE 8'h44
`define REG_SFR 8'h7C
`define REG_VEN 8'h7E
`define REG_PIN_SHARE_CONFIG 8'h7F
`define REG_FEN 8'h80
`define REG_TEN 8'h82
`define START_BIT 0
`define LOCK_BIT 1
`define READY_BIT 2
`define LOWPOWER_SELECT_BIT 0
`define GEN_BIT 2
`define GRP_BIT 0
`define DRV2_BIT 1
`define SNS3_BIT 0
`define TEN_REM1_BIT 1
`define TEN_AMB_BIT 2
`define TEN_REM2_BIT 3
`define ST1_REM1_BIT 5
`define ST1_AMB_BIT 6
`define ST1_REM2_BIT 7
`define DIODE_FAULT_CODE 8'h80
`define RST_CTRL 8'h00
`define RST_SFR 8'h00
`define RST_EN 8'hFF
`define RST_PIN_SHARE_CONFIG 8'h00
`define RST_LIM_LO 8'h00
`define RST_LIM_HI 8'hFF
`define NUM_LIM 16
`endif

/* File: verilog/lim_mem.v */
`timescale 1ns/1ps
`include "hwmon_alert_consts.vh"
// Limit store: 16 bytes, low/high pairs, registered read.
module lim_mem (
   input wire clk,
   input wire resetn,
   input wire we,
   input wire [3:0] waddr,
   input wire [7:0] wdata,
   input wire [3:0] raddr,
   output reg [7:0] rdata,
   output wire [127:0] flat
);
   reg [7:0] mem_q [0:15];
   integer i;
   genvar g;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (i = 0; i < `NUM_LIM; i = i + 1) begin
            mem_q[i] <= i[0] ? `RST_LIM_HI : `RST_LIM_LO;
         end
         rdata <= 8'h00;
      end else begin
         if (we) begin
            mem_q[waddr] <= wdata;
         end
         rdata <= mem_q[raddr];
      end
   end
   generate
      for (g = 0; g < 16; g = g + 1) begin : fl
         assign flat[g*8 +: 8] = mem_q[g];
      end
   endgenerate
endmodule

/* File: test/hwmon_alert_chk.sv */
`timescale 1ns/1ps
module hwmon_alert_chk (
   input wire clk,
   input wire resetn,
   input wire reg_rd,
   input wire reg_rvalid,
   input wire alert_response,
   input wire alert_n,
   input wire fan_drive_2_pin,
   input wire fan_drive_2_oe,
   input wire speed_sense_3_pin,
   input wire speed_sense_3_oe,
   input wire fans_full,
   input wire monitoring,
   input wire osc_run
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   chk_read_answer: assert property (reg_rd |=> reg_rvalid == $past(osc_run))
      else $error("read answer wrong");
   chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("read answer without request");
   chk_drive2_copy: assert property (fan_drive_2_oe |-> fan_drive_2_pin == alert_n)
      else $error("drive pin not alert copy");
   chk_sense3_copy: assert property (speed_sense_3_oe |-> speed_sense_3_pin == alert_n)
      else $error("sense pin not alert copy");
   chk_alert_mon: assert property (!monitoring && !$past(monitoring) |-> alert_n)
      else $error("alert while not monitoring");
   chk_alert_release: assert property (alert_response |-> ##[1:2] alert_n)
      else $error("alert not released");
   chk_fans_full: assert property (fans_full == !monitoring)
      else $error("fan duty wrong for mode");
   chk_osc_off: assert property (!osc_run |-> fans_full && !monitoring)
      else $error("oscillator off outside shutdown");
endmodule

/* File: test/smbus_host_model.sv */
`timescale 1ns/1ps
module smbus_host_model (
   input wire clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic alert_response
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      alert_response = 1'b0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = w;
      reg_rd = !w;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      // Released lines show a changed pattern so a stale value never looks valid.
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic status_rd(input logic [7:0] a);
      xfer(1'b1, 8'h7C, 8'h00);
      xfer(1'b0, a, 8'h00);
      xfer(1'b1, 8'h7C, 8'h04);
   endtask
   task automatic ara;
      @(negedge clk);
      alert_response = 1'b1;
      @(negedge clk);
      alert_response = 1'b0;
   endtask
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic clk, resetn, reg_wr, reg_rd, alert_response, conv_valid;
   logic [7:0] reg_addr, reg_wdata, conv_code, cv, exp_q[$];
   logic [2:0] conv_chan;
   logic [1:0] diode_fault;
   logic [3:0] fan_err;
   logic [4:0] cpu_voltage_code_pins;
   logic [15:0] rst_tab[7] = '{16'h7C00, 16'h7EFF, 16'h7F00, 16'h80FF, 16'h82FF, 16'h4000, 16'hF000};
   wire [7:0] reg_rdata;
   wire reg_rvalid, alert_n, fan_drive_2_pin, fan_drive_2_oe, speed_sense_3_pin, speed_sense_3_oe;
   wire fans_full, monitoring, osc_run;
   int err_total, check_count;
   hwmon_alert_and_power_ctrl hwmon_alert_and_power_ctrl_inst (.clk, .resetn, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .alert_response, .conv_valid, .conv_chan,
      .conv_code, .diode_fault, .fan_err, .cpu_voltage_code_pins, .alert_n, .fan_drive_2_pin,
      .fan_drive_2_oe, .speed_sense_3_pin, .speed_sense_3_oe, .fans_full, .monitoring, .osc_run);
   smbus_host_model host_inst (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .alert_response);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      check_count++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host_inst.xfer(1'b0, a, 8'h00);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host_inst.xfer(1'b1, a, d);
      repeat (2) @(negedge clk);
   endtask
   task automatic conv(input logic [2:0] ch, input logic [7:0] c);
      conv_chan = ch;
      conv_code = c;
      conv_valid = 1'b1;
      @(negedge clk);
      conv_valid = 1'b0;
      repeat (3) @(negedge clk);
   endtask
   task automatic end_of_test;
      if (exp_q.size() != 0) err_total++;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(negedge clk) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) chk("unexpected read", 8'h00, 8'hFF);
         else chk("read data", exp_q.pop_front(), reg_rdata);
      end
   end
   initial begin
      #400000;
      err_total++;
      end_of_test();
   end
   initial begin
      {resetn, conv_valid, conv_chan, conv_code, diode_fault, fan_err} = '0;
      cpu_voltage_code_pins = 5'h00;
      void'($urandom(32'h4178f91a));
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      foreach (rst_tab[i]) rd(rst_tab[i][15:8], rst_tab[i][7:0]);
      wr(8'h42, 8'hFF);
      rd(8'h42, 8'h00);
      wr(8'h7C, 8'h01);
      chk("osc_run", 8'h00, {7'b0, osc_run});
      chk("fans_full", 8'h01, {7'b0, fans_full});
      host_inst.xfer(1'b0, 8'h7C, 8'h00);
      wr(8'h40, 8'h01);
      chk("monitoring", 8'h00, {7'b0, monitoring});
      wr(8'h7C, 8'h00);
      rd(8'h7F, 8'h00);
      wr(8'h40, 8'h01);
      chk("monitoring", 8'h01, {7'b0, monitoring});
      cpu_voltage_code_pins = 5'($urandom);
      rd(8'h43, {3'b000, cpu_voltage_code_pins});
      wr(8'h7F, 8'h03);
      fan_err = 4'h1;
      wr(8'h7C, 8'h00);
      chk("alert off", 8'h01, {7'b0, alert_n});
      wr(8'h7C, 8'h04);
      chk("alert fan", 8'h00, {7'b0, alert_n});
      chk("drive2", 8'h02, {6'b0, fan_drive_2_oe, fan_drive_2_pin});
      chk("sense3", 8'h02, {6'b0, speed_sense_3_oe, speed_sense_3_pin});
      exp_q.push_back(8'h01);
      host_inst.status_rd(8'h42);
      fan_err = 4'h0;
      repeat (3) @(negedge clk);
      chk("alert held", 8'h00, {7'b0, alert_n});
      rd(8'h42, 8'h01);
      rd(8'h42, 8'h00);
      repeat (3) @(negedge clk);
      chk("alert clear", 8'h01, {7'b0, alert_n});
      wr(8'h44, 8'h20);
      cv = 8'($urandom % 32);
      conv(3'd0, cv);
      rd(8'h20, cv);
      chk("alert volt", 8'h00, {7'b0, alert_n});
      host_inst.ara();
      repeat (2) @(negedge clk);
      chk("alert ara", 8'h01, {7'b0, alert_n});
      diode_fault = 2'b01;
      conv(3'd5, 8'h33);
      rd(8'h25, 8'h80);
      rd(8'h41, 8'h21);
      rd(8'h42, 8'h40);
      wr(8'h7E, 8'h00);
      wr(8'h7C, 8'h00);
      wr(8'h7C, 8'h04);
      chk("alert temp", 8'h00, {7'b0, alert_n});
      wr(8'h82, 8'h00);
      chk("alert diode", 8'h01, {7'b0, alert_n});
      wr(8'h40, 8'h03);
      wr(8'h40, 8'h00);
      chk("locked", 8'h01, {7'b0, monitoring});
      repeat (4) @(negedge clk);
      end_of_test();
   end
endmodule
bind hwmon_alert_and_power_ctrl hwmon_alert_chk hwmon_alert_chk_inst (.clk, .resetn, .reg_rd, .reg_rvalid,
   .alert_response, .alert_n, .fan_drive_2_pin, .fan_drive_2_oe, .speed_sense_3_pin, .speed_sense_3_oe,
   .fans_full, .monitoring, .osc_run);
